// ### core/ddr3ps_top.sv
// ddr3 device command sampling, power states, init sequence and write masking
`timescale 1ns/1ps
`include "ddr3ps_cfg.svh"
module ddr3ps_top #(
  parameter int unsigned INIT_CYC = `DPS_INIT_CYC,
  parameter int unsigned DLLK_CYC = `DPS_DLLK_CYC,
  parameter int unsigned ZQINIT_CYC = `DPS_ZQINIT_CYC,
  parameter int unsigned SREF_TICK_CYC = `DPS_SREF_TICK_CYC
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire ddr3ps_pkg::ddr3ps_pins_t pins_in,
  output ddr3ps_pkg::ddr3ps_state_t state_out,
  output logic ready_out,
  output logic burst_busy_out,
  output logic refresh_pulse_out,
  output logic odt_term_en_out,
  output logic dll_reset_out,
  output logic illegal_out,
  output ddr3ps_pkg::ddr3ps_wr_t wr_out
);
  // decodes the sampled pins into a command; deselect folds into nop
  function automatic ddr3ps_pkg::ddr3ps_cmd_t dps_decode(input ddr3ps_pkg::ddr3ps_pins_t p);
    ddr3ps_pkg::ddr3ps_cmd_t c;
    c = ddr3ps_pkg::CMD_NOP;
    if (!p.cs_n) begin
      unique case ({p.ras_n, p.cas_n, p.we_n})
        `DPS_OP_MRS: c = ddr3ps_pkg::CMD_MRS;
        `DPS_OP_REF: c = ddr3ps_pkg::CMD_REF;
        `DPS_OP_PRE: c = ddr3ps_pkg::CMD_PRE;
        `DPS_OP_ACT: c = ddr3ps_pkg::CMD_ACT;
        `DPS_OP_WR: c = ddr3ps_pkg::CMD_WR;
        `DPS_OP_RD: c = ddr3ps_pkg::CMD_RD;
        `DPS_OP_ZQ: c = p.addr[`DPS_AP_BIT] ? ddr3ps_pkg::CMD_ZQCL : ddr3ps_pkg::CMD_ZQCS;
        `DPS_OP_NOP: c = ddr3ps_pkg::CMD_NOP;
      endcase
    end
    return c;
  endfunction

  localparam int unsigned CAL_CYC = (DLLK_CYC > ZQINIT_CYC) ? DLLK_CYC : ZQINIT_CYC;

  ddr3ps_pkg::ddr3ps_pins_t pins_meta_reg;
  ddr3ps_pkg::ddr3ps_pins_t pins_reg;
  ddr3ps_pkg::ddr3ps_state_t state_reg;
  ddr3ps_pkg::ddr3ps_state_t state_next;
  logic cke_prev_reg;
  logic cke_seen_reg;
  logic [31:0] init_cnt_reg;
  logic [31:0] cal_cnt_reg;
  logic cal_run_reg;
  logic ready_reg;
  logic [31:0] tick_cnt_reg;
  logic [7:0] open_reg;
  logic [7:0] open_next;
  logic [2:0] burst_cnt_reg;
  logic burst_wr_reg;
  logic burst_ap_reg;
  logic [2:0] burst_bank_reg;
  logic [12:0] mr_reg [4];
  logic illegal_next;

  // two flip-flops on every pin before anything reads it
  always_ff @(posedge clk_in) begin
    pins_meta_reg <= pins_in;
    pins_reg <= pins_meta_reg;
  end

  // command and cke edge decode
  wire ddr3ps_pkg::ddr3ps_cmd_t cmd = dps_decode(pins_reg);
  wire is_nop = (cmd == ddr3ps_pkg::CMD_NOP);
  wire cke_now = pins_reg.cke;
  wire cke_fall = cke_prev_reg && !cke_now;
  wire cke_rise = !cke_prev_reg && cke_now;
  wire cke_high = cke_prev_reg && cke_now;
  wire pin_reset = !pins_reg.reset_n;
  wire burst_busy = (burst_cnt_reg != 3'h0);
  wire burst_last = (burst_cnt_reg == 3'h1);
  wire in_op = (state_reg == ddr3ps_pkg::ST_IDLE) || (state_reg == ddr3ps_pkg::ST_ACTIVE);
  wire in_pd = (state_reg == ddr3ps_pkg::ST_APD) || (state_reg == ddr3ps_pkg::ST_PPD);
  wire live_cmd = in_op && cke_high;
  wire [1:0] bl_mode = mr_reg[0][`DPS_BL_LSB +: 2];
  wire otf_bc4 = (bl_mode == `DPS_BL_OTF) && !pins_reg.addr[`DPS_BC_BIT];
  wire [2:0] burst_len = ((bl_mode == `DPS_BL_BC4) || otf_bc4) ? `DPS_BC4_CYC : `DPS_BL8_CYC;
  wire rw_cmd = (cmd == ddr3ps_pkg::CMD_RD) || (cmd == ddr3ps_pkg::CMD_WR);
  // a new burst while one runs is refused, so the running one completes
  wire burst_start = live_cmd && rw_cmd && !burst_busy;
  wire [7:0] bank_bit = 8'h01 << pins_reg.ba;
  wire [7:0] ap_bit = 8'h01 << burst_bank_reg;
  // banks still open once the pending auto-precharge concludes
  wire [7:0] closing = open_reg & ~((burst_busy && burst_ap_reg) ? ap_bit : 8'h00);
  wire init_done = (init_cnt_reg >= INIT_CYC);
  wire sref_tick = (state_reg == ddr3ps_pkg::ST_SREF) && (tick_cnt_reg >= SREF_TICK_CYC);

  // bank open mask follows activate, precharge and auto-precharge
  always_comb begin
    open_next = open_reg;
    if (burst_last && burst_ap_reg) begin
      open_next = open_next & ~ap_bit;
    end
    if (live_cmd && (cmd == ddr3ps_pkg::CMD_ACT)) begin
      open_next = open_next | bank_bit;
    end
    if (live_cmd && (cmd == ddr3ps_pkg::CMD_PRE)) begin
      open_next = pins_reg.addr[`DPS_AP_BIT] ? 8'h00 : (open_next & ~bank_bit);
    end
  end

  // power state transitions; odt is deliberately absent from every term
  always_comb begin
    state_next = state_reg;
    illegal_next = 1'b0;
    unique case (state_reg)
      ddr3ps_pkg::ST_RESET: begin
        state_next = ddr3ps_pkg::ST_INIT;
      end
      ddr3ps_pkg::ST_INIT: begin
        // internal init runs off the count, not off cke or the pins
        if (cke_now && !init_done) begin
          illegal_next = 1'b1;
        end else if (cke_rise && is_nop) begin
          state_next = ddr3ps_pkg::ST_IDLE;
        end else if (cke_rise) begin
          illegal_next = 1'b1;
        end
      end
      ddr3ps_pkg::ST_IDLE, ddr3ps_pkg::ST_ACTIVE: begin
        if (cke_fall && (cmd == ddr3ps_pkg::CMD_REF)) begin
          // self refresh only from all banks idle with no burst
          if (state_reg == ddr3ps_pkg::ST_IDLE && !burst_busy && open_reg == 8'h00) begin
            state_next = ddr3ps_pkg::ST_SREF;
          end else begin
            illegal_next = 1'b1;
          end
        end else if (cke_fall) begin
          state_next = (closing == 8'h00) ? ddr3ps_pkg::ST_PPD : ddr3ps_pkg::ST_APD;
          illegal_next = !is_nop;
        end else if (cke_high) begin
          state_next = (open_next == 8'h00) ? ddr3ps_pkg::ST_IDLE : ddr3ps_pkg::ST_ACTIVE;
          illegal_next = rw_cmd && burst_busy;
        end else begin
          illegal_next = 1'b1;
        end
      end
      ddr3ps_pkg::ST_APD, ddr3ps_pkg::ST_PPD: begin
        // low-low holds; low-high exits to whichever op state matches the banks
        if (cke_rise) begin
          state_next = (open_reg == 8'h00) ? ddr3ps_pkg::ST_IDLE : ddr3ps_pkg::ST_ACTIVE;
          illegal_next = !is_nop;
        end
      end
      ddr3ps_pkg::ST_SREF: begin
        // exit taken on cke level alone, no previous-edge qualification
        if (cke_now) begin
          state_next = ddr3ps_pkg::ST_IDLE;
          illegal_next = !is_nop;
        end
      end
      default: begin
        state_next = ddr3ps_pkg::ST_RESET;
        illegal_next = 1'b1;
      end
    endcase
  end

  // state, cke history and init counters
  always_ff @(posedge clk_in) begin
    if (srst_in || pin_reset) begin
      state_reg <= ddr3ps_pkg::ST_RESET;
      cke_prev_reg <= 1'b0;
      cke_seen_reg <= 1'b0;
      init_cnt_reg <= 32'h0000_0000;
      illegal_out <= 1'b0;
    end else begin
      state_reg <= state_next;
      cke_prev_reg <= cke_now;
      cke_seen_reg <= cke_seen_reg || (state_next == ddr3ps_pkg::ST_IDLE);
      init_cnt_reg <= init_done ? init_cnt_reg : init_cnt_reg + 32'h0000_0001;
      illegal_out <= illegal_next;
    end
  end

  // calibration wait: ready only after both dll lock and zq init expire
  always_ff @(posedge clk_in) begin
    if (srst_in || pin_reset) begin
      cal_run_reg <= 1'b0;
      cal_cnt_reg <= 32'h0000_0000;
      ready_reg <= 1'b0;
    end else if (live_cmd && cmd == ddr3ps_pkg::CMD_ZQCL && !ready_reg) begin
      cal_run_reg <= 1'b1;
      cal_cnt_reg <= 32'h0000_0000;
    end else if (cal_run_reg) begin
      cal_cnt_reg <= cal_cnt_reg + 32'h0000_0001;
      if (cal_cnt_reg + 32'h0000_0001 >= CAL_CYC) begin
        cal_run_reg <= 1'b0;
        ready_reg <= 1'b1;
      end
    end
  end

  // mode registers; dll reset bit drops the cycle after it is taken
  always_ff @(posedge clk_in) begin
    if (srst_in || pin_reset) begin
      for (int i = 0; i < 4; i++) begin
        mr_reg[i] <= `DPS_MR_RST;
      end
    end else if (live_cmd && cmd == ddr3ps_pkg::CMD_MRS && !pins_reg.ba[2]) begin
      mr_reg[pins_reg.ba[1:0]] <= pins_reg.addr;
    end else begin
      mr_reg[0][`DPS_DLL_RST_BIT] <= 1'b0;
    end
  end

  // burst tracker; nop and deselect leave a running burst untouched
  always_ff @(posedge clk_in) begin
    if (srst_in || pin_reset) begin
      burst_cnt_reg <= 3'h0;
      burst_wr_reg <= 1'b0;
      burst_ap_reg <= 1'b0;
      burst_bank_reg <= 3'h0;
      open_reg <= 8'h00;
    end else begin
      open_reg <= open_next;
      if (burst_start) begin
        burst_cnt_reg <= burst_len;
        burst_wr_reg <= (cmd == ddr3ps_pkg::CMD_WR);
        burst_ap_reg <= pins_reg.addr[`DPS_AP_BIT];
        burst_bank_reg <= pins_reg.ba;
      end else if (burst_busy) begin
        burst_cnt_reg <= burst_cnt_reg - 3'h1;
      end
    end
  end

  // self refresh ticker runs only in self refresh, never in power-down
  always_ff @(posedge clk_in) begin
    if (srst_in || pin_reset || state_reg != ddr3ps_pkg::ST_SREF || sref_tick) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end

  // registered outputs
  always_ff @(posedge clk_in) begin
    if (srst_in || pin_reset) begin
      refresh_pulse_out <= 1'b0;
      odt_term_en_out <= 1'b0;
      wr_out <= '0;
      burst_busy_out <= 1'b0;
    end else begin
      refresh_pulse_out <= (live_cmd && cmd == ddr3ps_pkg::CMD_REF) || sref_tick;
      // termination high-z until cke seen and always in self refresh
      odt_term_en_out <= pins_reg.odt && cke_seen_reg && in_op;
      wr_out.be <= (burst_busy && burst_wr_reg) ? ~pins_reg.dm : 2'h0;
      wr_out.data <= pins_reg.dq;
      burst_busy_out <= burst_start || (burst_busy && !burst_last);
    end
  end

  assign state_out = state_reg;
  assign ready_out = ready_reg;
  assign dll_reset_out = mr_reg[0][`DPS_DLL_RST_BIT];
endmodule // ddr3ps_top

// ### core/ddr3ps_cfg.svh
// constants for the ddr3 command, power state and init tracker
// Operation
// - commands decode from cs, ras, cas, we and cke sampled on rising clock
// - started read or write bursts run to completion, never cut short
// - power-down performs no refresh operations
// - termination unavailable in self refresh; odt never steers state changes
// - nop and deselect act alike and never abort a running burst
// - cke low-low holds power state; low-high with nop or deselect exits
// - refresh with falling cke enters self refresh, only from all-banks-idle
// - entry picks precharge power-down if banks closed, else active power-down
// - self-refresh exit recognised without the synchronous cke edge check
// - during writes, mask low stores the byte, mask high blocks it
// - controller waits 500 us after reset before cke; device initialises meanwhile
// - termination off during reset until cke registers high; odt static afterwards
// - after long calibration, wait dll lock and calibration times, then normal
// - only truth table encodings are recognised as commands
// - dll reset bit of mode register 0 clears itself after the reset
`ifndef DDR3PS_CFG_SVH
`define DDR3PS_CFG_SVH
`define DPS_CLK_MHZ 200
`define DPS_T_INIT_US 500
`define DPS_INIT_CYC (`DPS_T_INIT_US * `DPS_CLK_MHZ)
`define DPS_DLLK_CYC 512
`define DPS_ZQINIT_CYC 512
`define DPS_SREF_TICK_CYC 1560
`define DPS_BL8_CYC 3'h4
`define DPS_BC4_CYC 3'h2
`define DPS_BL_LSB 0
`define DPS_BL_OTF 2'h1
`define DPS_BL_BC4 2'h2
`define DPS_DLL_RST_BIT 8
`define DPS_AP_BIT 10
`define DPS_BC_BIT 12
`define DPS_OP_MRS 3'h0
`define DPS_OP_REF 3'h1
`define DPS_OP_PRE 3'h2
`define DPS_OP_ACT 3'h3
`define DPS_OP_WR 3'h4
`define DPS_OP_RD 3'h5
`define DPS_OP_ZQ 3'h6
`define DPS_OP_NOP 3'h7
`define DPS_MR_RST 13'h0000
`endif

// ### core/ddr3ps_pkg.sv
// types shared by the ddr3 power state tracker
package ddr3ps_pkg;
  typedef struct packed {
    logic reset_n;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic odt;
    logic [2:0] ba;
    logic [12:0] addr;
    logic [1:0] dm;
    logic [15:0] dq;
  } ddr3ps_pins_t;

  typedef struct packed {
    logic [1:0] be;
    logic [15:0] data;
  } ddr3ps_wr_t;

  typedef enum logic [3:0] {
    CMD_NOP, CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT, CMD_WR, CMD_RD, CMD_ZQCL, CMD_ZQCS
  } ddr3ps_cmd_t;

  // gray steps along reset, init, idle, active, power-down, self refresh
  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_INIT = 3'h1,
    ST_IDLE = 3'h3,
    ST_ACTIVE = 3'h2,
    ST_APD = 3'h6,
    ST_PPD = 3'h7,
    ST_SREF = 3'h5
  } ddr3ps_state_t;
endpackage

// ### dv/ddr3ps_top_monitor.sv
// concurrent checks on the ddr3 power state tracker ports
`timescale 1ns/1ps
module ddr3ps_top_monitor (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire ddr3ps_pkg::ddr3ps_pins_t pins_in,
  input wire ddr3ps_pkg::ddr3ps_state_t state_out,
  input wire logic ready_out,
  input wire logic burst_busy_out,
  input wire logic refresh_pulse_out,
  input wire logic odt_term_en_out,
  input wire logic dll_reset_out,
  input wire ddr3ps_pkg::ddr3ps_wr_t wr_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // cke low for five samples while parked in a power state
  sequence s_low_hold;
    (!pins_in.cke && state_out inside {ddr3ps_pkg::ST_APD, ddr3ps_pkg::ST_PPD,
      ddr3ps_pkg::ST_SREF})[*5];
  endsequence
  // reset must clear state even while it is asserted, so no disable here
  a_reset_clears: assert property (disable iff (1'b0) srst_in |=>
    state_out == ddr3ps_pkg::ST_RESET && !ready_out && !odt_term_en_out)
    else $error("outputs not cleared by reset");
  a_odt_off_sref: assert property (state_out == ddr3ps_pkg::ST_SREF &&
    $past(state_out) == ddr3ps_pkg::ST_SREF |-> !odt_term_en_out)
    else $error("termination on in self refresh");
  a_odt_off_init: assert property (state_out == ddr3ps_pkg::ST_INIT |-> !odt_term_en_out)
    else $error("termination on before cke registered");
  a_burst_min_len: assert property ($rose(burst_busy_out) |-> burst_busy_out[*2])
    else $error("burst cut short");
  // each beat's enables land one cycle behind the busy flag that covers it
  a_mask_gate: assert property (wr_out.be != 2'h0 |-> $past(burst_busy_out))
    else $error("byte enable outside write burst");
  a_dll_clears: assert property (dll_reset_out |=> !dll_reset_out)
    else $error("dll reset bit did not clear");
  a_ready_after_init: assert property (ready_out |->
    !(state_out inside {ddr3ps_pkg::ST_RESET, ddr3ps_pkg::ST_INIT}))
    else $error("ready before init finished");
  a_sref_from_idle: assert property (state_out == ddr3ps_pkg::ST_SREF &&
    $past(state_out) != ddr3ps_pkg::ST_SREF |-> $past(state_out) == ddr3ps_pkg::ST_IDLE)
    else $error("self refresh entered from non idle");
  a_apd_from_active: assert property (state_out == ddr3ps_pkg::ST_APD &&
    $past(state_out) != ddr3ps_pkg::ST_APD |-> $past(state_out) == ddr3ps_pkg::ST_ACTIVE)
    else $error("active power-down without open bank");
  a_pd_no_refresh: assert property (state_out inside {ddr3ps_pkg::ST_APD,
    ddr3ps_pkg::ST_PPD} && $past(state_out, 2) == state_out |-> !refresh_pulse_out)
    else $error("refresh during power-down");
  a_low_holds: assert property (s_low_hold |-> $stable(state_out))
    else $error("power state left with cke low");
endmodule // ddr3ps_top_monitor

// ### dv/ddr3ps_ctrl_model.sv
// controller-side model driving the ddr3 command and control pins
`timescale 1ns/1ps
module ddr3ps_ctrl_model #(
  parameter int unsigned RST_CYC = 16
) (
  input wire logic clk_in,
  output ddr3ps_pkg::ddr3ps_pins_t pins_out
);
  // reset pin low at power-up with cke low; hold shortened for sim
  initial begin
    pins_out = '0;
    pins_out.cs_n = 1'b1;
    pins_out.dm = 2'h3;
    repeat (RST_CYC) @(posedge clk_in);
    pins_out.reset_n <= 1'b1;
  end
  // one command edge, then nop for hold cycles keeping cke steady
  task automatic cmd(input logic [3:0] op, input logic cke, input logic [2:0] ba,
      input logic [12:0] addr, input int unsigned hold);
    @(posedge clk_in);
    pins_out.cke <= cke;
    {pins_out.cs_n, pins_out.ras_n, pins_out.cas_n, pins_out.we_n} <= op;
    pins_out.ba <= ba;
    pins_out.addr <= addr;
    @(posedge clk_in);
    {pins_out.cs_n, pins_out.ras_n, pins_out.cas_n, pins_out.we_n} <= 4'h7;
    repeat (hold) @(posedge clk_in);
  endtask
  // four write beats; released data flips so stale values never match
  task automatic beats(input logic [7:0] dm, input logic [63:0] dq);
    for (int i = 0; i < 4; i++) begin
      pins_out.dm <= dm[2*i +: 2];
      pins_out.dq <= dq[16*i +: 16];
      @(posedge clk_in);
    end
    pins_out.dm <= 2'h3;
    pins_out.dq <= ~pins_out.dq;
  endtask
endmodule // ddr3ps_ctrl_model

// ### dv/tb.sv
// self-checking bench for the ddr3 power state tracker
`timescale 1ns/1ps
module tb;
  localparam logic [3:0] OP_MRS = 4'h0;
  localparam logic [3:0] OP_REF = 4'h1;
  localparam logic [3:0] OP_PRE = 4'h2;
  localparam logic [3:0] OP_ACT = 4'h3;
  localparam logic [3:0] OP_WR = 4'h4;
  localparam logic [3:0] OP_RD = 4'h5;
  localparam logic [3:0] OP_ZQ = 4'h6;
  localparam logic [3:0] OP_NOP = 4'h7;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  ddr3ps_pkg::ddr3ps_pins_t pins_in;
  ddr3ps_pkg::ddr3ps_state_t state_out;
  logic ready_out, burst_busy_out, refresh_pulse_out, odt_term_en_out, dll_reset_out;
  logic illegal_out;
  ddr3ps_pkg::ddr3ps_wr_t wr_out;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  logic ill_seen = 1'b0;
  always #2.5 clk_in = ~clk_in;
  ddr3ps_ctrl_model m (.clk_in, .pins_out(pins_in));
  // short counts keep the run brief
  ddr3ps_top #(.INIT_CYC(20), .DLLK_CYC(8), .ZQINIT_CYC(8), .SREF_TICK_CYC(10)) dut (
    .clk_in, .srst_in, .pins_in, .state_out, .ready_out, .burst_busy_out,
    .refresh_pulse_out, .odt_term_en_out, .dll_reset_out, .illegal_out, .wr_out);
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic fail(input string msg);
    err_count++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    num_checks++;
    if (got !== exp) fail(msg);
  endtask
  task automatic chk_state(input ddr3ps_pkg::ddr3ps_state_t exp);
    num_checks++;
    if (state_out !== exp) fail("state");
  endtask
  task automatic chk_wr(input logic [17:0] exp);
    num_checks++;
    if (wr_out !== exp) fail("write beat");
  endtask
  // sample just after the edge so outputs have settled
  task automatic tick(input int unsigned n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wait_state(input ddr3ps_pkg::ddr3ps_state_t exp);
    for (int i = 0; i < 8 && state_out !== exp; i++) tick(1);
    chk_state(exp);
  endtask
  // cycle ceiling plus sticky capture of the registered illegal flag, high for one cycle or several
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (illegal_out === 1'b1) ill_seen <= 1'b1;
    if (cyc == 3000) begin
      fail("timeout");
      end_of_test();
    end
  end
  task automatic t_init();
    tick(28);
    chk_state(ddr3ps_pkg::ST_INIT);
    m.cmd(OP_NOP, 1'b0, 3'h0, 13'h0000, 2);
    m.cmd(OP_NOP, 1'b1, 3'h0, 13'h0000, 6);
    wait_state(ddr3ps_pkg::ST_IDLE);
    chk_bit(ill_seen, 1'b0, "init flagged");
    m.cmd(OP_MRS, 1'b1, 3'h2, 13'h0000, 4);
    m.cmd(OP_MRS, 1'b1, 3'h3, 13'h0000, 4);
    m.cmd(OP_MRS, 1'b1, 3'h1, 13'h0000, 4);
    m.cmd(OP_MRS, 1'b1, 3'h0, 13'h0100, 0);
    for (int i = 0; i < 8 && dll_reset_out !== 1'b1; i++) tick(1);
    chk_bit(dll_reset_out, 1'b1, "dll reset not set");
    tick(1);
    chk_bit(dll_reset_out, 1'b0, "dll reset stuck");
    chk_bit(ready_out, 1'b0, "ready too early");
    m.cmd(OP_ZQ, 1'b1, 3'h0, 13'h0400, 0);
    for (int i = 0; i < 30 && ready_out !== 1'b1; i++) tick(1);
    chk_bit(ready_out, 1'b1, "not ready");
  endtask
  // write with every mask pattern and a refused read in mid-burst
  task automatic t_write();
    logic [17:0] exp [4] = '{18'h0_4444, 18'h1_3333, 18'h2_2222, 18'h3_1111};
    int nb = 0;
    logic was_busy = 1'b0;
    m.cmd(OP_ACT, 1'b1, 3'h0, 13'h0000, 3);
    wait_state(ddr3ps_pkg::ST_ACTIVE);
    ill_seen = 1'b0;
    m.cmd(OP_WR, 1'b1, 3'h0, 13'h0000, 0);
    fork
      m.beats(8'h1B, 64'h1111_2222_3333_4444);
      m.cmd(OP_RD, 1'b1, 3'h0, 13'h0000, 0);
      // each beat's enables show up one cycle after the busy flag covering it
      for (int i = 0; i < 12; i++) begin
        tick(1);
        if (was_busy && nb < 4) chk_wr(exp[nb]);
        if (was_busy) nb++;
        was_busy = (burst_busy_out === 1'b1);
      end
    join
    chk_bit(nb == 4, 1'b1, "burst length");
    chk_bit(ill_seen, 1'b1, "read in burst not flagged");
  endtask
  task automatic t_pd();
    m.cmd(OP_NOP, 1'b0, 3'h0, 13'h0000, 8);
    wait_state(ddr3ps_pkg::ST_APD);
    m.cmd(OP_NOP, 1'b1, 3'h0, 13'h0000, 4);
    wait_state(ddr3ps_pkg::ST_ACTIVE);
    ill_seen = 1'b0;
    m.cmd(OP_REF, 1'b0, 3'h0, 13'h0000, 4);
    chk_bit(ill_seen, 1'b1, "refresh entry from active");
    m.cmd(OP_NOP, 1'b1, 3'h0, 13'h0000, 4);
    wait_state(ddr3ps_pkg::ST_ACTIVE);
    m.cmd(OP_PRE, 1'b1, 3'h0, 13'h0400, 4);
    wait_state(ddr3ps_pkg::ST_IDLE);
    m.cmd(OP_NOP, 1'b0, 3'h0, 13'h0000, 8);
    wait_state(ddr3ps_pkg::ST_PPD);
    m.cmd(OP_NOP, 1'b1, 3'h0, 13'h0000, 4);
    wait_state(ddr3ps_pkg::ST_IDLE);
  endtask
  task automatic t_sref();
    int n = 0;
    @(posedge clk_in);
    m.pins_out.odt <= 1'b1;
    tick(4);
    chk_bit(odt_term_en_out, 1'b1, "termination off in idle");
    m.cmd(OP_REF, 1'b0, 3'h0, 13'h0000, 0);
    wait_state(ddr3ps_pkg::ST_SREF);
    for (int i = 0; i < 30; i++) begin
      tick(1);
      if (refresh_pulse_out === 1'b1) n++;
    end
    chk_bit(odt_term_en_out, 1'b0, "termination in self refresh");
    chk_bit(n >= 2, 1'b1, "no refresh in self refresh");
    m.cmd(OP_NOP, 1'b1, 3'h0, 13'h0000, 0);
    wait_state(ddr3ps_pkg::ST_IDLE);
    // no write may follow until this many clocks after the exit
    tick(512);
    chk_bit(odt_term_en_out, 1'b1, "termination lost");
  endtask
  initial begin
    repeat (16) @(posedge clk_in);
    srst_in <= 1'b0;
    t_init();
    t_write();
    t_pd();
    t_sref();
    end_of_test();
  end
endmodule // tb
bind ddr3ps_top ddr3ps_top_monitor mon (.clk_in, .srst_in, .pins_in, .state_out, .ready_out,
  .burst_busy_out, .refresh_pulse_out, .odt_term_en_out, .dll_reset_out, .wr_out);
